// File: bench/cgpo_calib_bench.sv
// self-checking bench for the calibration engine
`timescale 1ns/1ps
module cgpo_calib_bench;
    logic mclk = 1'b0, resetn = 1'b0, dc_mode = 1'b0, ack;
    logic adc_valid = 1'b0, calc_valid = 1'b0;
    logic [9:0] thermistor = 10'h155;
    logic [23:0] expected_current = 0, expected_voltage = 0;
    logic [23:0] expected_power = 0, adc_current_raw = 0;
    logic [23:0] adc_voltage_raw = 0, current_rms_raw = 0;
    logic [23:0] voltage_rms_raw = 0, active_power_raw = 0;
    logic [31:0] reactive_power_scaled = 32'h3E8;
    logic [15:0] d;
    wire reg_wr, reg_rd, cal_start, cal_busy, cal_done, cal_ack;
    wire adc_code_valid, hpf_enable;
    wire [4:0] reg_addr;
    wire [15:0] reg_wdata, reg_rdata;
    wire [23:0] adc_current_code, adc_voltage_code;
    wire [31:0] current_rms, voltage_rms, active_power, reactive_power;
    wire [7:0] phase_adjust, samples_per_cycle;
    int n_errors = 0;
    int n_checks = 0;

    always #2 mclk = ~mclk;

    cgpo_calib u_cgpo_calib (.mclk, .resetn, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .dc_mode, .thermistor, .cal_start,
        .expected_current, .expected_voltage, .expected_power, .cal_busy,
        .cal_done, .cal_ack, .adc_valid, .adc_current_raw, .adc_voltage_raw,
        .adc_current_code, .adc_voltage_code, .adc_code_valid, .calc_valid,
        .current_rms_raw, .voltage_rms_raw, .active_power_raw,
        .reactive_power_scaled, .current_rms, .voltage_rms, .active_power,
        .reactive_power, .hpf_enable, .phase_adjust, .samples_per_cycle);
    cgpo_host u_cgpo_host (.mclk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .cal_start, .cal_done, .cal_ack);

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, ex);
        n_checks++;
        if (seen !== ex) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic rdc(input logic [4:0] a, input logic [15:0] ex);
        u_cgpo_host.rd(a, d);
        chk($sformatf("reg %h", a), {16'h0, d}, {16'h0, ex});
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        u_cgpo_host.wr(a, v);
    endtask
    task automatic adc(input logic [23:0] ci, cv, ei, ev);
        @(posedge mclk);
        adc_valid <= 1'b1;
        adc_current_raw <= ci;
        adc_voltage_raw <= cv;
        @(posedge mclk);
        adc_valid <= 1'b0;
        @(negedge mclk);
        chk("code i", {8'h0, adc_current_code}, {8'h0, ei});
        chk("code v", {8'h0, adc_voltage_code}, {8'h0, ev});
    endtask
    // outputs settle one cycle after the strobe is taken
    task automatic calc(input logic [23:0] i, v, p);
        @(posedge mclk);
        calc_valid <= 1'b1;
        current_rms_raw <= i;
        voltage_rms_raw <= v;
        active_power_raw <= p;
        @(posedge mclk);
        calc_valid <= 1'b0;
        @(negedge mclk);
    endtask
    task automatic cal_run(input logic [23:0] ei, ev, ep, input logic ax);
        @(posedge mclk);
        expected_current <= ei;
        expected_voltage <= ev;
        expected_power <= ep;
        u_cgpo_host.cal(ack);
        chk("ack", {31'h0, ack}, {31'h0, ax});
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        rdc(5'h00, 16'h8000);
        rdc(5'h0F, 16'hFFFF);
        rdc(5'h10, 16'h7D80);
        rdc(5'h11, 16'hEC00);
        adc(24'h000300, 24'h001000, 24'hFF8080, 24'hFFFC00);
        wr(5'h0F, 16'h0102);
        wr(5'h10, 16'h0304);
        wr(5'h11, 16'h0506);
        wr(5'h1F, 16'h1234);
        adc(24'h000300, 24'h001000, 24'h020604, 24'h011506);
        rdc(5'h1F, 16'h0000);
        $display("test trims done");
        // unity scaling so measured equals raw
        wr(5'h06, 16'h000F);
        wr(5'h07, 16'h000F);
        wr(5'h08, 16'h000F);
        calc(24'd1150, 24'd1000, 24'd1000);
        cal_run(24'd1000, 24'd1500, 24'd1000, 1'b1);
        rdc(5'h00, 16'h6F4D);
        rdc(5'h01, 16'hC000);
        rdc(5'h02, 16'h8000);
        rdc(5'h12, 16'h0155);
        @(posedge mclk) thermistor <= 10'h0AA;
        cal_run(24'd800, 24'd1000, 24'd1000, 1'b0);
        rdc(5'h00, 16'h6F4D);
        rdc(5'h12, 16'h00AA);
        cal_run(24'd3000, 24'd1000, 24'd1000, 1'b0);
        rdc(5'h00, 16'h6F4D);
        @(posedge mclk) dc_mode <= 1'b1;
        cal_run(24'd2000, 24'd1000, 24'd1000, 1'b1);
        rdc(5'h03, 16'hDE9B);
        rdc(5'h00, 16'h6F4D);
        $display("test calibration done");
        wr(5'h06, 16'h000E);
        wr(5'h0C, 16'h0007);
        calc(24'd1150, 24'd1000, 24'd1000);
        chk("i rms dc", current_rms, 32'h0FA6);
        chk("q dc", reactive_power, 32'h03E8);
        chk("hpf", {31'h0, hpf_enable}, 32'h0);
        @(posedge mclk) dc_mode <= 1'b0;
        wr(5'h09, 16'h0005);
        wr(5'h0B, 16'h0003);
        wr(5'h0A, 16'h0002);
        calc(24'd1150, 24'd1000, 24'd1000);
        chk("i rms ac", current_rms, 32'h07D4);
        chk("q ac", reactive_power, 32'h03EB);
        chk("p ac", active_power, 32'h03EA);
        chk("v ac", voltage_rms, 32'h05DC);
        $display("test scaling done");
        wr(5'h0E, 16'h12F0);
        u_cgpo_host.phase_fix(25);
        repeat (2) @(negedge mclk);
        chk("phase", {24'h0, phase_adjust}, 32'h54);
        chk("samples", {24'h0, samples_per_cycle}, 32'h38);
        rdc(5'h0E, 16'h1254);
        $display("test phase done");
        stop_test();
    end

    // watchdog well past the expected few hundred cycles
    initial begin
        #100000;
        n_errors++;
        stop_test();
    end
endmodule

// File: bench/cgpo_host.sv
// host model issuing register accesses and calibration commands
`timescale 1ns/1ps
module cgpo_host (
    input  wire         mclk,
    output logic        reg_wr,
    output logic        reg_rd,
    output logic [4:0]  reg_addr,
    output logic [15:0] reg_wdata,
    input  wire  [15:0] reg_rdata,
    output logic        cal_start,
    input  wire         cal_done,
    input  wire         cal_ack
);
    // idle bus from time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        cal_start = 1'b0;
    end
    // one-cycle write strobe
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // read data lands one cycle after the strobe is taken
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        v = reg_rdata;
    endtask
    // angle error in tenths of a degree, times 4, folded into 8 bits
    task automatic phase_fix(input int tenths);
        logic [15:0] p;
        rd(5'h0E, p);
        wr(5'h0E, {p[15:8], p[7:0] + 8'(tenths * 4)});
    endtask
    // range is picked by the bench for unity scaling; expected values put gains in or out of the window
    task automatic cal(output logic ack);
        int i;
        @(posedge mclk);
        cal_start <= 1'b1;
        @(posedge mclk);
        cal_start <= 1'b0;
        for (i = 0; i < 400 && cal_done !== 1'b1; i++) @(negedge mclk);
        ack = (cal_done === 1'b1) ? cal_ack : 1'bx;
    endtask
endmodule

// File: bench/cgpo_monitor.sv
// concurrent checks on the calibration engine ports
`timescale 1ns/1ps
module cgpo_monitor (
    input wire       mclk,
    input wire       resetn,
    input wire       cal_start,
    input wire       cal_busy,
    input wire       cal_done,
    input wire       cal_ack,
    input wire       adc_valid,
    input wire       adc_code_valid,
    input wire       dc_mode,
    input wire       hpf_enable,
    input wire [7:0] samples_per_cycle
);
    // ------------------------------------------------------------
    // one clock domain, reset masks every check
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // an accepted command raises busy next edge, no instant result
    start_busy_a: assert property (cal_start && !cal_busy |=> cal_busy && !cal_done)
        else $error("busy not raised by command");
    // the result must arrive within a bounded span
    done_bound_a: assert property ($rose(cal_busy) |-> ##[1:300] cal_done)
        else $error("calibration never finished");
    // busy may only drop together with the result pulse
    busy_hold_a: assert property (cal_busy && !cal_done |=> cal_busy || cal_done)
        else $error("busy dropped without result");
    // result is a single pulse closing a busy span
    done_pulse_a: assert property (cal_done |-> !cal_busy && $past(cal_busy) ##1 !cal_done)
        else $error("bad result pulse");
    // ack/nak verdict only moves with a result
    ack_stable_a: assert property (!cal_done |-> $stable(cal_ack))
        else $error("verdict changed without result");
    // trimmed codes follow raw codes by one edge
    code_valid_a: assert property ($past(resetn) |-> adc_code_valid == $past(adc_valid))
        else $error("code valid lag wrong");
    // high-pass filters off in dc operation
    hpf_dc_a: assert property ($past(resetn) |-> hpf_enable == !$past(dc_mode))
        else $error("filter enable wrong");
    // phase step basis is fixed
    samples_a: assert property (samples_per_cycle == 8'h38)
        else $error("samples per cycle wrong");
endmodule

bind cgpo_calib cgpo_monitor u_cgpo_monitor (
    .mclk, .resetn, .cal_start, .cal_busy, .cal_done, .cal_ack,
    .adc_valid, .adc_code_valid, .dc_mode, .hpf_enable, .samples_per_cycle
);

// File: src/cgpo_calib.v
// calibration engine: auto gain update, range scaling, offsets, phase, trims
// Operation
// - new gain below 25000 fails the calibration and answers nak
// - new gain above 65535 cannot be stored and also fails
// - in-range new gain old*expected/measured is stored and answered ack
// - range gives right shifts applied after multiplying by the gain
// - 56 samples per line cycle, one sample about 6.43 degrees
// - phase value is signed, half a sample either way
// - phase adjustment is taken from the low byte of phase register
// - ac offsets for current rms, active and reactive power after scaling
// - dc mode turns off high-pass filters and uses the dc offsets
// - upper trim register holds voltage bits 15-8, current bits 7-0
// - each channel has a 16-bit low trim word register
// - trims join into 24-bit signed offset added to channel code
// - ack only when all three new gains lie in 25000..65535
// - auto gain copies thermistor value into ambient reference register
// - ac mode updates ac gains, dc mode updates dc gains
`timescale 1ns/1ps
`include "cgpo_regs.vh"
module cgpo_calib #(
    parameter DW = 24
) (
    input  wire          mclk,
    input  wire          resetn,
    input  wire          reg_wr,
    input  wire          reg_rd,
    input  wire [4:0]    reg_addr,
    input  wire [15:0]   reg_wdata,
    output reg  [15:0]   reg_rdata,
    input  wire          dc_mode,
    input  wire [9:0]    thermistor,
    input  wire          cal_start,
    input  wire [DW-1:0] expected_current,
    input  wire [DW-1:0] expected_voltage,
    input  wire [DW-1:0] expected_power,
    output reg           cal_busy,
    output reg           cal_done,
    output reg           cal_ack,
    input  wire          adc_valid,
    input  wire [23:0]   adc_current_raw,
    input  wire [23:0]   adc_voltage_raw,
    output reg  [23:0]   adc_current_code,
    output reg  [23:0]   adc_voltage_code,
    output reg           adc_code_valid,
    input  wire          calc_valid,
    input  wire [DW-1:0] current_rms_raw,
    input  wire [DW-1:0] voltage_rms_raw,
    input  wire [DW-1:0] active_power_raw,
    input  wire [31:0]   reactive_power_scaled,
    output reg  [31:0]   current_rms,
    output reg  [31:0]   voltage_rms,
    output reg  [31:0]   active_power,
    output reg  [31:0]   reactive_power,
    output reg           hpf_enable,
    output reg  [7:0]    phase_adjust,
    output reg  [7:0]    samples_per_cycle
);

    localparam ST_IDLE  = 2'h0;
    localparam ST_DIV   = 2'h1;
    localparam ST_WAIT  = 2'h2;
    localparam ST_CHECK = 2'h3;

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    reg [15:0] gain_mem [0:5];
    reg [7:0]  range_mem [0:2];
    reg [15:0] ofs_mem [0:4];
    reg [15:0] phase_reg;
    reg [15:0] trim_high_reg;
    reg [15:0] trim_cur_low_reg;
    reg [15:0] trim_volt_low_reg;
    reg [9:0]  ambient_ref_reg;
    reg [1:0]  state_reg;
    reg [1:0]  qty_reg;
    reg        dc_lat_reg;
    reg [39:0] newgain_mem [0:2];
    reg        div_start_reg;
    integer    i;

    wire        div_done;
    wire [39:0] div_q;
    wire [39:0] div_num;
    wire [2:0]  gbase;
    reg  [15:0] old_gain;
    reg  [DW-1:0] exp_sel;
    reg  [DW-1:0] meas_sel;

    // product then right shifts, one halving per range step
    function [31:0] scale;
        input [DW-1:0] val;
        input [15:0]   gain;
        input [7:0]    shifts;
        reg   [39:0]   prod;
        begin
            prod  = val * gain;
            prod  = prod >> shifts[5:0];
            scale = prod[31:0];
        end
    endfunction

    // sign-extend a 16-bit offset term
    function [31:0] sext16;
        input [15:0] v;
        begin
            sext16 = {{16{v[15]}}, v};
        end
    endfunction

    // window check on a truncated quotient
    function in_window;
        input [39:0] g;
        begin
            in_window = (g >= `CGPO_GAIN_MIN) && (g <= `CGPO_GAIN_MAX);
        end
    endfunction

    // ------------------------------------------------------------
    // operand selection for the quantity under calibration
    // ------------------------------------------------------------
    assign gbase = dc_lat_reg ? 3'h3 : 3'h0;

    always @* begin
        old_gain = gain_mem[gbase + {1'b0, qty_reg}];
        case (qty_reg)
            2'h0: begin
                exp_sel  = expected_current;
                meas_sel = current_rms[DW-1:0];
            end
            2'h1: begin
                exp_sel  = expected_voltage;
                meas_sel = voltage_rms[DW-1:0];
            end
            default: begin
                exp_sel  = expected_power;
                meas_sel = active_power[DW-1:0];
            end
        endcase
    end

    // truncating divider shared by all three quantities
    assign div_num = {24'h000000, old_gain} * {16'h0000, exp_sel};
    cgpo_divider #(
        .NUM_W (40),
        .DEN_W (DW)
    ) u_div (
        .mclk     (mclk),
        .resetn   (resetn),
        .start    (div_start_reg),
        .dividend (div_num),
        .divisor  (meas_sel),
        .done     (div_done),
        .quotient (div_q)
    );

    // ------------------------------------------------------------
    // register file and auto gain sequencer
    // ------------------------------------------------------------
    // a passing calibration overrides a host write to the same gain
    always @(posedge mclk) begin
        if (!resetn) begin
            for (i = 0; i < 6; i = i + 1)
                gain_mem[i] <= `CGPO_RST_GAIN;
            for (i = 0; i < 3; i = i + 1) begin
                range_mem[i]   <= `CGPO_RST_RANGE;
                newgain_mem[i] <= 40'h0000000000;
            end
            for (i = 0; i < 5; i = i + 1)
                ofs_mem[i] <= 16'h0000;
            phase_reg         <= 16'h0000;
            trim_high_reg     <= `CGPO_RST_TRIM_HIGH;
            trim_cur_low_reg  <= `CGPO_RST_TRIM_CUR_LOW;
            trim_volt_low_reg <= `CGPO_RST_TRIM_VOLT_LOW;
            ambient_ref_reg   <= 10'h000;
            state_reg         <= ST_IDLE;
            qty_reg           <= 2'h0;
            dc_lat_reg        <= 1'b0;
            div_start_reg     <= 1'b0;
            cal_busy          <= 1'b0;
            cal_done          <= 1'b0;
            cal_ack           <= 1'b0;
        end else begin
            div_start_reg <= 1'b0;
            cal_done      <= 1'b0;
            if (reg_wr) begin
                case (reg_addr)
                    `CGPO_IDX_GAIN_I_AC, `CGPO_IDX_GAIN_V_AC,
                    `CGPO_IDX_GAIN_P_AC, `CGPO_IDX_GAIN_I_DC,
                    `CGPO_IDX_GAIN_V_DC, `CGPO_IDX_GAIN_P_DC:
                        gain_mem[reg_addr[2:0]] <= reg_wdata;
                    `CGPO_IDX_RANGE_I: range_mem[0] <= reg_wdata[7:0];
                    `CGPO_IDX_RANGE_V: range_mem[1] <= reg_wdata[7:0];
                    `CGPO_IDX_RANGE_P: range_mem[2] <= reg_wdata[7:0];
                    `CGPO_IDX_OFS_I_AC:  ofs_mem[0] <= reg_wdata;
                    `CGPO_IDX_OFS_P_AC:  ofs_mem[1] <= reg_wdata;
                    `CGPO_IDX_OFS_Q_AC:  ofs_mem[2] <= reg_wdata;
                    `CGPO_IDX_OFS_I_DC:  ofs_mem[3] <= reg_wdata;
                    `CGPO_IDX_OFS_P_DC:  ofs_mem[4] <= reg_wdata;
                    `CGPO_IDX_PHASE:     phase_reg  <= reg_wdata;
                    `CGPO_IDX_TRIM_HIGH: trim_high_reg <= reg_wdata;
                    `CGPO_IDX_TRIM_CUR_LOW:
                        trim_cur_low_reg <= reg_wdata;
                    `CGPO_IDX_TRIM_VOLT_LOW:
                        trim_volt_low_reg <= reg_wdata;
                    `CGPO_IDX_AMBIENT_REF:
                        ambient_ref_reg <= reg_wdata[9:0];
                    default: ;
                endcase
            end
            case (state_reg)
                ST_IDLE: begin
                    if (cal_start) begin
                        dc_lat_reg      <= dc_mode;
                        qty_reg         <= 2'h0;
                        cal_busy        <= 1'b1;
                        ambient_ref_reg <= thermistor;
                        state_reg       <= ST_DIV;
                    end
                end
                ST_DIV: begin
                    div_start_reg <= 1'b1;
                    state_reg     <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (div_done) begin
                        newgain_mem[qty_reg] <= div_q;
                        if (qty_reg == 2'h2) begin
                            state_reg <= ST_CHECK;
                        end else begin
                            qty_reg   <= qty_reg + 2'h1;
                            state_reg <= ST_DIV;
                        end
                    end
                end
                ST_CHECK: begin
                    // all three must pass or nothing is written
                    if (in_window(newgain_mem[0]) &&
                        in_window(newgain_mem[1]) &&
                        in_window(newgain_mem[2])) begin
                        for (i = 0; i < 3; i = i + 1)
                            gain_mem[gbase + i[2:0]] <=
                                newgain_mem[i][15:0];
                        cal_ack <= 1'b1;
                    end else begin
                        cal_ack <= 1'b0;
                    end
                    cal_done  <= 1'b1;
                    cal_busy  <= 1'b0;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // register readback, unmapped indices read zero
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (!resetn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `CGPO_IDX_GAIN_I_AC, `CGPO_IDX_GAIN_V_AC,
                `CGPO_IDX_GAIN_P_AC, `CGPO_IDX_GAIN_I_DC,
                `CGPO_IDX_GAIN_V_DC, `CGPO_IDX_GAIN_P_DC:
                    reg_rdata <= gain_mem[reg_addr[2:0]];
                `CGPO_IDX_RANGE_I:  reg_rdata <= {8'h00, range_mem[0]};
                `CGPO_IDX_RANGE_V:  reg_rdata <= {8'h00, range_mem[1]};
                `CGPO_IDX_RANGE_P:  reg_rdata <= {8'h00, range_mem[2]};
                `CGPO_IDX_OFS_I_AC: reg_rdata <= ofs_mem[0];
                `CGPO_IDX_OFS_P_AC: reg_rdata <= ofs_mem[1];
                `CGPO_IDX_OFS_Q_AC: reg_rdata <= ofs_mem[2];
                `CGPO_IDX_OFS_I_DC: reg_rdata <= ofs_mem[3];
                `CGPO_IDX_OFS_P_DC: reg_rdata <= ofs_mem[4];
                `CGPO_IDX_PHASE:    reg_rdata <= phase_reg;
                `CGPO_IDX_TRIM_HIGH:     reg_rdata <= trim_high_reg;
                `CGPO_IDX_TRIM_CUR_LOW:  reg_rdata <= trim_cur_low_reg;
                `CGPO_IDX_TRIM_VOLT_LOW: reg_rdata <= trim_volt_low_reg;
                `CGPO_IDX_AMBIENT_REF:
                    reg_rdata <= {6'h00, ambient_ref_reg};
                `CGPO_IDX_STATUS:
                    reg_rdata <= {13'h0000, dc_mode, cal_ack, cal_busy};
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // adc trim: 24-bit two's complement offset added to each code
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (!resetn) begin
            adc_current_code <= 24'h000000;
            adc_voltage_code <= 24'h000000;
            adc_code_valid   <= 1'b0;
        end else begin
            adc_code_valid <= adc_valid;
            if (adc_valid) begin
                adc_current_code <= adc_current_raw +
                    {trim_high_reg[7:0], trim_cur_low_reg};
                adc_voltage_code <= adc_voltage_raw +
                    {trim_high_reg[15:8], trim_volt_low_reg};
            end
        end
    end

    // ------------------------------------------------------------
    // gain, range and offset scaling of the computed quantities
    // ------------------------------------------------------------
    // offsets follow scaling so they are in output units
    always @(posedge mclk) begin
        if (!resetn) begin
            current_rms    <= 32'h00000000;
            voltage_rms    <= 32'h00000000;
            active_power   <= 32'h00000000;
            reactive_power <= 32'h00000000;
        end else if (calc_valid) begin
            current_rms <= scale(current_rms_raw,
                gain_mem[3'h0 + (dc_mode ? 3'h3 : 3'h0)], range_mem[0]) +
                sext16(dc_mode ? ofs_mem[3] : ofs_mem[0]);
            voltage_rms <= scale(voltage_rms_raw,
                gain_mem[3'h1 + (dc_mode ? 3'h3 : 3'h0)], range_mem[1]);
            active_power <= scale(active_power_raw,
                gain_mem[3'h2 + (dc_mode ? 3'h3 : 3'h0)], range_mem[2]) +
                sext16(dc_mode ? ofs_mem[4] : ofs_mem[1]);
            reactive_power <= reactive_power_scaled +
                (dc_mode ? 32'h00000000 : sext16(ofs_mem[2]));
        end
    end

    // ------------------------------------------------------------
    // filter control and phase step outputs
    // ------------------------------------------------------------
    // only the low byte is used; the high byte is storage only
    always @(posedge mclk) begin
        if (!resetn) begin
            hpf_enable        <= 1'b1;
            phase_adjust      <= 8'h00;
            samples_per_cycle <= `CGPO_SAMPLES_PER_CYCLE;
        end else begin
            hpf_enable        <= !dc_mode;
            phase_adjust      <= phase_reg[7:0];
            samples_per_cycle <= `CGPO_SAMPLES_PER_CYCLE;
        end
    end

endmodule

// File: src/cgpo_divider.v
// restoring divider computing a truncated quotient for the gain update
`timescale 1ns/1ps
module cgpo_divider #(
    parameter NUM_W = 40,
    parameter DEN_W = 24
) (
    input  wire             mclk,
    input  wire             resetn,
    input  wire             start,
    input  wire [NUM_W-1:0] dividend,
    input  wire [DEN_W-1:0] divisor,
    output reg              done,
    output reg  [NUM_W-1:0] quotient
);

    reg [DEN_W:0]   rem_reg;
    reg [NUM_W-1:0] num_reg;
    reg [DEN_W-1:0] den_reg;
    reg [6:0]       cnt_reg;
    reg             busy_reg;
    wire [DEN_W:0]  trial;
    wire [DEN_W:0]  diff;

    // shift next dividend bit into the partial remainder
    assign trial = {rem_reg[DEN_W-1:0], num_reg[NUM_W-1]};
    assign diff  = trial - {1'b0, den_reg};

    // ------------------------------------------------------------
    // one quotient bit per cycle; fractional part is dropped
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (!resetn) begin
            rem_reg  <= {(DEN_W+1){1'b0}};
            num_reg  <= {NUM_W{1'b0}};
            den_reg  <= {DEN_W{1'b0}};
            cnt_reg  <= 7'h00;
            busy_reg <= 1'b0;
            done     <= 1'b0;
            quotient <= {NUM_W{1'b0}};
        end else begin
            done <= 1'b0;
            if (start && !busy_reg) begin
                rem_reg  <= {(DEN_W+1){1'b0}};
                num_reg  <= dividend;
                den_reg  <= divisor;
                cnt_reg  <= NUM_W[6:0];
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                // zero divisor sets the upper 24 quotient bits to ones, which fails any range check
                if (!diff[DEN_W]) begin
                    rem_reg <= diff;
                    num_reg <= {num_reg[NUM_W-2:0], 1'b1};
                end else begin
                    rem_reg <= trial;
                    num_reg <= {num_reg[NUM_W-2:0], 1'b0};
                end
                cnt_reg <= cnt_reg - 7'h01;
                if (cnt_reg == 7'h01) begin
                    busy_reg <= 1'b0;
                    done     <= 1'b1;
                    if (!diff[DEN_W])
                        quotient <= {num_reg[NUM_W-2:0], 1'b1};
                    else
                        quotient <= {num_reg[NUM_W-2:0], 1'b0};
                end
            end
        end
    end

endmodule

// File: src/cgpo_regs.vh
// register indices, reset values and calibration limits of the calibration block
`ifndef CGPO_REGS_VH
`define CGPO_REGS_VH

// ------------------------------------------------------------
// register indices
// ------------------------------------------------------------
`define CGPO_IDX_GAIN_I_AC     5'h00
`define CGPO_IDX_GAIN_V_AC     5'h01
`define CGPO_IDX_GAIN_P_AC     5'h02
`define CGPO_IDX_GAIN_I_DC     5'h03
`define CGPO_IDX_GAIN_V_DC     5'h04
`define CGPO_IDX_GAIN_P_DC     5'h05
`define CGPO_IDX_RANGE_I       5'h06
`define CGPO_IDX_RANGE_V       5'h07
`define CGPO_IDX_RANGE_P       5'h08
`define CGPO_IDX_OFS_I_AC      5'h09
`define CGPO_IDX_OFS_P_AC      5'h0A
`define CGPO_IDX_OFS_Q_AC      5'h0B
`define CGPO_IDX_OFS_I_DC      5'h0C
`define CGPO_IDX_OFS_P_DC      5'h0D
`define CGPO_IDX_PHASE         5'h0E
`define CGPO_IDX_TRIM_HIGH     5'h0F
`define CGPO_IDX_TRIM_CUR_LOW  5'h10
`define CGPO_IDX_TRIM_VOLT_LOW 5'h11
`define CGPO_IDX_AMBIENT_REF   5'h12
`define CGPO_IDX_STATUS        5'h13

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CGPO_RST_GAIN          16'h8000
`define CGPO_RST_RANGE         8'h00
`define CGPO_RST_TRIM_HIGH     16'hFFFF
`define CGPO_RST_TRIM_CUR_LOW  16'h7D80
`define CGPO_RST_TRIM_VOLT_LOW 16'hEC00

// ------------------------------------------------------------
// status field positions
// ------------------------------------------------------------
`define CGPO_ST_BUSY           0
`define CGPO_ST_ACK            1
`define CGPO_ST_DC             2

// ------------------------------------------------------------
// calibration limits and phase step
// ------------------------------------------------------------
`define CGPO_GAIN_MIN          40'h00000061A8
`define CGPO_GAIN_MAX          40'h000000FFFF
`define CGPO_SAMPLES_PER_CYCLE 8'h38

`endif
